// ===== pbs_sram_port.sv
// pipelined burst sram port: input registers, burst control, output and strobes
`include "pbs_regs.svh"

module pbs_sram_port
    import pbs_pkg::*;
#(
    parameter int WORDS = `PBS_WORDS
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_power_on_rst_n,
    input wire logic i_strobe_clk_in,
    input wire logic [`PBS_HI_ADDR_W-1:0] i_addr_in,
    input wire logic i_burst_addr_hi_in,
    input wire logic i_burst_addr_lo_in,
    input wire logic i_burst_start_n,
    input wire logic i_chip_sel_n_first,
    input wire logic i_chip_sel_high,
    input wire logic i_chip_sel_n_third,
    input wire logic i_write_sel_n,
    input wire logic [`PBS_GRP_W-1:0] i_data_io_group_a,
    input wire logic [`PBS_GRP_W-1:0] i_data_io_group_b,
    output logic [`PBS_GRP_W-1:0] o_data_io_group_a,
    output logic [`PBS_GRP_W-1:0] o_data_io_group_b,
    output logic o_data_oe_group_a,
    output logic o_data_oe_group_b,
    output logic o_strobe_out_group_a,
    output logic o_strobe_out_group_a_n,
    output logic o_strobe_out_group_b,
    output logic o_strobe_out_group_b_n
);

    pbs_arr_if arr_if ();

    // ------------------------------------------------------------
    // input registers
    // ------------------------------------------------------------
    logic ads_n_r;
    logic sel_r;
    logic wsel_n_r;
    logic [`PBS_HI_ADDR_W-1:0] addr_r;
    logic [1:0] lo_r;
    logic [`PBS_DATA_W-1:0] din_r;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ads_n_r <= 1'b1;
            sel_r <= 1'b0;
            wsel_n_r <= 1'b1;
            addr_r <= '0;
            lo_r <= 2'h0;
            din_r <= '0;
        end else begin
            ads_n_r <= i_burst_start_n;
            sel_r <= ~i_chip_sel_n_first & i_chip_sel_high & ~i_chip_sel_n_third;
            wsel_n_r <= i_write_sel_n;
            addr_r <= i_addr_in;
            lo_r <= {i_burst_addr_hi_in, i_burst_addr_lo_in};
            din_r <= {i_data_io_group_b, i_data_io_group_a};
        end
    end

    // ------------------------------------------------------------
    // burst state machine
    // ------------------------------------------------------------
    pbs_state_e state_r;
    pbs_state_e state_nxt;
    logic [`PBS_HI_ADDR_W-1:0] base_r;
    logic [`PBS_HI_ADDR_W-1:0] base_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic [1:0] left_r;
    logic [1:0] left_nxt;
    logic beat_vld;
    logic beat_wr;
    logic [`PBS_ADDR_W-1:0] beat_addr;
    logic start;
    logic desel;

    assign start = ~ads_n_r & sel_r;
    assign desel = ~ads_n_r & ~sel_r;

    always_comb begin
        state_nxt = state_r;
        base_nxt = base_r;
        cnt_nxt = cnt_r;
        left_nxt = left_r;
        beat_vld = 1'b0;
        beat_wr = 1'b0;
        beat_addr = {base_r, cnt_r};
        if (start) begin
            beat_vld = 1'b1;
            beat_wr = ~wsel_n_r;
            beat_addr = {addr_r, lo_r};
            base_nxt = addr_r;
            cnt_nxt = lo_r + `PBS_CNT_STEP;
            left_nxt = `PBS_BURST_LAST;
            state_nxt = wsel_n_r ? PBS_READ : PBS_WRITE;
        end else if (desel) begin
            state_nxt = PBS_IDLE;
            left_nxt = 2'h0;
        end else begin
            case (state_r)
                PBS_READ, PBS_WRITE: begin
                    beat_vld = 1'b1;
                    beat_wr = (state_r == PBS_WRITE);
                    cnt_nxt = cnt_r + `PBS_CNT_STEP;
                    left_nxt = left_r - `PBS_CNT_STEP;
                    if (left_r == `PBS_CNT_STEP) begin
                        state_nxt = PBS_IDLE;
                    end
                end
                PBS_IDLE: begin
                    state_nxt = PBS_IDLE;
                end
                default: begin
                    state_nxt = PBS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_power_on_rst_n) begin
        if (!i_power_on_rst_n) begin
            state_r <= PBS_IDLE;
            base_r <= '0;
            cnt_r <= 2'h0;
            left_r <= 2'h0;
        end else if (i_sys_rst) begin
            state_r <= PBS_IDLE;
            base_r <= '0;
            cnt_r <= 2'h0;
            left_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            base_r <= base_nxt;
            cnt_r <= cnt_nxt;
            left_r <= left_nxt;
        end
    end

    // ------------------------------------------------------------
    // late write: address held one cycle, data from input register
    // ------------------------------------------------------------
    logic wpend_r;
    logic wpend_nxt;
    logic [`PBS_ADDR_W-1:0] waddr_r;
    logic [`PBS_ADDR_W-1:0] waddr_nxt;

    always_comb begin
        wpend_nxt = beat_vld & beat_wr;
        waddr_nxt = beat_addr;
    end

    always_ff @(posedge i_mclk or negedge i_power_on_rst_n) begin
        if (!i_power_on_rst_n) begin
            wpend_r <= 1'b0;
            waddr_r <= '0;
        end else if (i_sys_rst) begin
            wpend_r <= 1'b0;
            waddr_r <= '0;
        end else begin
            wpend_r <= wpend_nxt;
            waddr_r <= waddr_nxt;
        end
    end

    assign arr_if.wr_en = wpend_r;
    assign arr_if.wr_addr = waddr_r;
    assign arr_if.wr_data = din_r;
    assign arr_if.rd_en = beat_vld & ~beat_wr;
    assign arr_if.rd_addr = beat_addr;

    pbs_array #(
        .WORDS(WORDS),
        .DATA_W(`PBS_DATA_W)
    ) u_array (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .arr(arr_if.arr)
    );

    // ------------------------------------------------------------
    // output register and pin drive
    // ------------------------------------------------------------
    logic [`PBS_DATA_W-1:0] dout_r;
    logic [`PBS_DATA_W-1:0] dout_nxt;
    logic oe_r;
    logic oe_nxt;
    logic tog_r;
    logic tog_nxt;

    always_comb begin
        dout_nxt = arr_if.rd_vld ? arr_if.rd_data : dout_r;
        oe_nxt = arr_if.rd_vld;
        tog_nxt = tog_r ^ arr_if.rd_vld;
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            dout_r <= '0;
            oe_r <= 1'b0;
            tog_r <= 1'b0;
        end else begin
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            tog_r <= tog_nxt;
        end
    end

    assign o_data_io_group_a = dout_r[`PBS_GRP_W-1:0];
    assign o_data_io_group_b = dout_r[`PBS_DATA_W-1:`PBS_GRP_W];
    assign o_data_oe_group_a = oe_r;
    assign o_data_oe_group_b = oe_r;

    // ------------------------------------------------------------
    // strobe clock sampling and strobe registers
    // ------------------------------------------------------------
    logic [`PBS_SYNC_STAGES-1:0] sk_sync_r;
    logic sk_prev_r;
    logic sk_prev_nxt;
    logic sk_rise;
    logic stra_r;
    logic stra_nxt;
    logic strb_r;
    logic strb_nxt;

    always_comb begin
        sk_prev_nxt = sk_prev_r;
        if (sk_sync_r[1] == sk_sync_r[2]) begin
            sk_prev_nxt = sk_sync_r[2];
        end
        sk_rise = (sk_sync_r[1] == sk_sync_r[2]) & sk_sync_r[2] & ~sk_prev_r;
        stra_nxt = sk_rise ? tog_r : stra_r;
        strb_nxt = sk_rise ? tog_r : strb_r;
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sk_sync_r <= '0;
            sk_prev_r <= 1'b0;
            stra_r <= 1'b0;
            strb_r <= 1'b0;
            o_strobe_out_group_a <= 1'b0;
            o_strobe_out_group_a_n <= 1'b1;
            o_strobe_out_group_b <= 1'b0;
            o_strobe_out_group_b_n <= 1'b1;
        end else begin
            sk_sync_r <= {sk_sync_r[`PBS_SYNC_STAGES-2:0], i_strobe_clk_in};
            sk_prev_r <= sk_prev_nxt;
            stra_r <= stra_nxt;
            strb_r <= strb_nxt;
            o_strobe_out_group_a <= stra_nxt;
            o_strobe_out_group_a_n <= ~stra_nxt;
            o_strobe_out_group_b <= strb_nxt;
            o_strobe_out_group_b_n <= ~strb_nxt;
        end
    end

endmodule : pbs_sram_port

// ===== pbs_regs.svh
// constants of the pipelined burst sram port
`ifndef PBS_REGS_SVH
`define PBS_REGS_SVH

`define PBS_ADDR_W 16
`define PBS_HI_ADDR_W 14
`define PBS_DATA_W 36
`define PBS_GRP_W 18
`define PBS_WORDS 65536
`define PBS_BURST_LEN 4
`define PBS_BURST_LAST 2'h3
`define PBS_CNT_STEP 2'h1
`define PBS_STROBE_PHASE_DEG 180
`define PBS_SYNC_STAGES 3

`endif

// ===== pbs_pkg.sv
// types of the pipelined burst sram port
package pbs_pkg;

    typedef enum logic [1:0] {
        PBS_IDLE = 2'b00,
        PBS_READ = 2'b01,
        PBS_WRITE = 2'b10
    } pbs_state_e;

endpackage : pbs_pkg

// ===== pbs_arr_if.sv
// carrier between burst control and storage array
`include "pbs_regs.svh"

interface pbs_arr_if;
    logic rd_en;
    logic [`PBS_ADDR_W-1:0] rd_addr;
    logic wr_en;
    logic [`PBS_ADDR_W-1:0] wr_addr;
    logic [`PBS_DATA_W-1:0] wr_data;
    logic [`PBS_DATA_W-1:0] rd_data;
    logic rd_vld;

    modport ctl (output rd_en, rd_addr, wr_en, wr_addr, wr_data, input rd_data, rd_vld);
    modport arr (input rd_en, rd_addr, wr_en, wr_addr, wr_data, output rd_data, rd_vld);
endinterface : pbs_arr_if

// ===== pbs_array.sv
// storage array with registered read port and late write port
`include "pbs_regs.svh"

module pbs_array
    import pbs_pkg::*;
#(
    parameter int WORDS = `PBS_WORDS,
    parameter int DATA_W = `PBS_DATA_W
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    pbs_arr_if.arr arr
);

    localparam int AW = $clog2(WORDS);

    logic [DATA_W-1:0] mem [WORDS];
    // index wraps when the array is smaller than the address space
    logic [AW-1:0] rd_idx;
    logic [AW-1:0] wr_idx;

    assign rd_idx = arr.rd_addr[AW-1:0];
    assign wr_idx = arr.wr_addr[AW-1:0];
    logic [DATA_W-1:0] q_r;
    logic [DATA_W-1:0] q_nxt;
    logic q_vld_r;
    logic q_vld_nxt;

    // ------------------------------------------------------------
    // read with bypass of a write landing in the same cycle
    // ------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        q_vld_nxt = arr.rd_en;
        if (arr.rd_en) begin
            if (arr.wr_en && (wr_idx == rd_idx)) begin
                q_nxt = arr.wr_data;
            end else begin
                q_nxt = mem[rd_idx];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (arr.wr_en) begin
            mem[wr_idx] <= arr.wr_data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            q_r <= '0;
            q_vld_r <= 1'b0;
        end else begin
            q_r <= q_nxt;
            q_vld_r <= q_vld_nxt;
        end
    end

    assign arr.rd_data = q_r;
    assign arr.rd_vld = q_vld_r;

endmodule : pbs_array

// ===== pbs_sram_port_properties.sv
// pin-level assertions for the burst sram port
module pbs_port_chk (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_power_on_rst_n,
    input wire logic i_strobe_clk_in,
    input wire logic i_burst_start_n,
    input wire logic i_chip_sel_n_first,
    input wire logic i_chip_sel_high,
    input wire logic i_chip_sel_n_third,
    input wire logic i_write_sel_n,
    input wire logic o_data_oe_group_a,
    input wire logic o_data_oe_group_b,
    input wire logic o_strobe_out_group_a,
    input wire logic o_strobe_out_group_a_n,
    input wire logic o_strobe_out_group_b,
    input wire logic o_strobe_out_group_b_n
);
    logic en;
    logic rd;
    logic sk_d_r;
    logic [3:0] since_rd_r, since_rd_nxt, since_sk_r, since_sk_nxt;
    assign en = !i_chip_sel_n_first && i_chip_sel_high && !i_chip_sel_n_third;
    assign rd = !i_burst_start_n && en && i_write_sel_n;
    // cycles since a selected read start and since a strobe clock rise
    always_comb begin
        since_rd_nxt = (since_rd_r == 4'hF) ? 4'hF : since_rd_r + 4'h1;
        since_sk_nxt = (since_sk_r == 4'hF) ? 4'hF : since_sk_r + 4'h1;
        if (rd) since_rd_nxt = 4'h0;
        if (i_strobe_clk_in && !sk_d_r) since_sk_nxt = 4'h0;
    end
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !i_power_on_rst_n) begin
            since_rd_r <= 4'hF;
            since_sk_r <= 4'h0;
        end else begin
            since_rd_r <= since_rd_nxt;
            since_sk_r <= since_sk_nxt;
        end
        sk_d_r <= i_strobe_clk_in;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst || !i_power_on_rst_n);
    property p_rd_first;
        rd ##1 i_burst_start_n |-> ##2 o_data_oe_group_a;
    endproperty
    a_rd_first: assert property (p_rd_first) else $error("first read beat late");
    property p_burst;
        rd ##1 i_burst_start_n[*4] |-> o_data_oe_group_a && $past(o_data_oe_group_a)
            ##1 o_data_oe_group_a[*2] ##1 !o_data_oe_group_a;
    endproperty
    a_burst: assert property (p_burst) else $error("read burst not four beats");
    property p_oe_cause;
        o_data_oe_group_a |-> since_rd_r <= 4'h5;
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("data driven without read");
    property p_oe_groups;
        o_data_oe_group_b == o_data_oe_group_a;
    endproperty
    a_oe_groups: assert property (p_oe_groups) else $error("group enables differ");
    property p_strobe_pairs;
        o_strobe_out_group_a_n == !o_strobe_out_group_a
            && o_strobe_out_group_b == o_strobe_out_group_a
            && o_strobe_out_group_b_n == !o_strobe_out_group_a;
    endproperty
    a_strobe_pairs: assert property (p_strobe_pairs)
        else $error("strobe pair mismatch");
    property p_strobe_clk;
        $changed(o_strobe_out_group_a) |-> since_sk_r inside {[4'h1:4'h7]};
    endproperty
    a_strobe_clk: assert property (p_strobe_clk)
        else $error("strobe moved off strobe clock");
    property p_wr_quiet;
        !i_burst_start_n && en && !i_write_sel_n && since_rd_r > 4'h6 ##1 i_burst_start_n[*6]
            |-> !o_data_oe_group_a;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("write drove data pins");
    property p_desel;
        !i_burst_start_n && !en && since_rd_r > 4'h6 ##1 i_burst_start_n[*6]
            |-> !o_data_oe_group_a;
    endproperty
    a_desel: assert property (p_desel) else $error("deselected port drove data");
    property p_por;
        disable iff (i_sys_rst) !i_power_on_rst_n[*4] |-> !o_data_oe_group_a;
    endproperty
    a_por: assert property (p_por) else $error("data driven in power-on reset");
endmodule : pbs_port_chk

bind pbs_sram_port pbs_port_chk u_chk (.*);

// ===== pbs_ctl_model.sv
// controller side: strobe clock and data pins toward the port
module pbs_ctl_model (
    input wire logic i_mclk,
    input wire logic i_drive,
    input wire logic [35:0] i_word,
    output logic o_strobe_clk,
    output logic [35:0] o_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [35:0] last_r = 36'h0;
    initial begin
        o_strobe_clk = 1'b0;
        #7;
        forever #160 o_strobe_clk = ~o_strobe_clk;
    end
    // released pins flip every cycle
    assign o_pins = i_drive ? i_word : ~last_r;
    always @(posedge i_mclk) last_r <= o_pins;
endmodule : pbs_ctl_model

// ===== testbench.sv
// self-checking bench for the burst sram port
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk = 1'b0, i_sys_rst = 1'b1, po_n = 1'b0, start_n = 1'b1, wsel_n = 1'b1;
    logic s1 = 1'b1, s2 = 1'b0, s3 = 1'b1, hi = 1'b0, lo = 1'b0, drv = 1'b0;
    logic sk, oea, oeb, sa, san, sb;
    logic [13:0] addr = 14'h0;
    logic [35:0] word = 36'h0, pins, mem [256];
    logic [17:0] qa, qb;
    int n_mismatch = 0, checks = 0, seed = 52, cyc = 0;
    always #20 i_mclk = ~i_mclk;
    pbs_ctl_model u_ctl (.i_mclk(i_mclk), .i_drive(drv), .i_word(word), .o_strobe_clk(sk),
        .o_pins(pins));
    pbs_sram_port #(.WORDS(256)) dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_power_on_rst_n(po_n), .i_strobe_clk_in(sk), .i_addr_in(addr),
        .i_burst_addr_hi_in(hi), .i_burst_addr_lo_in(lo), .i_burst_start_n(start_n),
        .i_chip_sel_n_first(s1), .i_chip_sel_high(s2), .i_chip_sel_n_third(s3),
        .i_write_sel_n(wsel_n), .i_data_io_group_a(pins[17:0]),
        .i_data_io_group_b(pins[35:18]), .o_data_io_group_a(qa), .o_data_io_group_b(qb),
        .o_data_oe_group_a(oea), .o_data_oe_group_b(oeb), .o_strobe_out_group_a(sa),
        .o_strobe_out_group_a_n(san), .o_strobe_out_group_b(sb), .o_strobe_out_group_b_n());
    task automatic conclude();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [7:0] beat(logic [7:0] a, int k);
        return {a[7:2], a[1:0] + k[1:0]};
    endfunction : beat
    task automatic op(logic wr, logic [2:0] en, logic [7:0] a);
        logic [35:0] w;
        @(posedge i_mclk);
        start_n <= 1'b0;
        {s1, s2, s3} <= en;
        wsel_n <= !wr;
        addr <= {8'($random(seed)), a[7:2]};
        {hi, lo} <= a[1:0];
        for (int j = 0; j < 6; j++) begin
            @(posedge i_mclk);
            start_n <= 1'b1;
            addr <= 14'($random(seed));
            w = 36'({$random(seed), $random(seed)});
            drv <= wr && j < 4;
            word <= w;
            if (wr && j < 4 && en == 3'b010) mem[beat(a, j)] = w;
            if (j >= 2) begin
                #1;
                check("oe", 36'(oea), 36'(!wr && en == 3'b010));
                check("oeb", 36'(oeb), 36'(!wr && en == 3'b010));
                if (!wr && en == 3'b010) check("rd", {qb, qa}, mem[beat(a, j - 2)]);
            end
        end
    endtask : op
    initial begin
        int r;
        repeat (8) @(posedge i_mclk);
        #7 po_n = 1'b1;
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        for (int i = 0; i < 256; i += 4) op(1'b1, 3'b010, 8'(i));
        op(1'b1, 3'b010, 8'h07);
        op(1'b0, 3'b010, 8'h07);
        for (int e = 0; e < 8; e++) op(1'b0, 3'(e), 8'h10);
        repeat (60) begin
            r = $random(seed);
            op(r[3], r[4] ? 3'b010 : r[2:0], r[15:8]);
        end
        @(posedge i_mclk);
        start_n <= 1'b0;
        wsel_n <= 1'b1;
        {s1, s2, s3} <= 3'b010;
        @(posedge i_mclk);
        start_n <= 1'b1;
        #5 po_n = 1'b0;
        repeat (5) @(posedge i_mclk);
        #1 check("oe", 36'(oea), 36'h0);
        #4 po_n = 1'b1;
        op(1'b0, 3'b010, 8'h21);
        conclude();
    end
endmodule : testbench
